/* design/flash_host_pkg.sv */
package flash_host_pkg;

  // ************************************************************
  // command and address codes driven onto the flash bus, the erased byte value and the signature length
  // ************************************************************
  localparam logic [7:0] CMD_SIGNATURE = 8'h90;
  localparam logic [7:0] ADDR_SIGNATURE = 8'h00;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int SIGNATURE_ITEMS = 4;

  // ************************************************************
  // status byte fields read back from the flash
  // ************************************************************
  localparam int SR_FAIL_BIT = 0;
  localparam int SR_READY_BIT = 6;
  localparam int SR_UNLOCK_BIT = 7;

  // ************************************************************
  // signature byte 3 and item 4 fields
  // ************************************************************
  localparam int B3_DIE_LSB = 0;
  localparam int B3_CELL_LSB = 2;
  localparam int B3_PAGES_LSB = 4;
  localparam int B3_INTERLEAVE_BIT = 6;
  localparam int B3_CACHE_BIT = 7;
  localparam int B4_PAGE_LSB = 0;
  localparam int B4_SPARE_BIT = 2;
  localparam int B4_ACC_LO_BIT = 3;
  localparam int B4_BLOCK_LSB = 4;
  localparam int B4_WIDE_BIT = 6;
  localparam int B4_ACC_HI_BIT = 7;

  // ************************************************************
  // software register map (word index on the command port)
  // ************************************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_BLOCK_ADDR = 4'h1;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h2;
  localparam logic [3:0] REG_IRQ_MASK = 4'h3;
  localparam logic [3:0] REG_ID_LO = 4'h4;
  localparam logic [3:0] REG_ID_HI = 4'h5;
  localparam logic [3:0] REG_GEOMETRY = 4'h6;
  localparam logic [3:0] REG_FLASH_STATUS = 4'h7;
  localparam logic [3:0] REG_MARKER = 4'h8;

  // control register: bit 0..2 start one operation, bit 3 write-lock release
  localparam int CTRL_ID_BIT = 0;
  localparam int CTRL_MARK_BIT = 1;
  localparam int CTRL_ERASE_BIT = 2;
  localparam int CTRL_UNLOCK_BIT = 3;

  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_BAD = 2;
  localparam int IRQ_REFUSED = 3;
  localparam int IRQ_WIDTH = 4;

  // ************************************************************
  // bus timing: 100 MHz system clock
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_NS = 30;
  localparam int STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // cycles after a confirm before ready/busy is trusted: covers the device's
  // delay in dropping ready plus the synchroniser lag
  localparam int BUSY_SETTLE_CYCLES = 8;

  typedef enum logic [1:0] {
    CYC_CMD,
    CYC_ADDR,
    CYC_READ
  } cycle_kind_t;

endpackage

/* design/flash_bus_cycle.sv */
`timescale 1ns/1ps
`default_nettype none
// one bus cycle on the flash pins: command, address or data read
module flash_bus_cycle #(
  parameter int WIDTH = 16,
  parameter int HOLD = flash_host_pkg::STROBE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire flash_host_pkg::cycle_kind_t kind,
  input wire logic [7:0] value,
  input wire logic [WIDTH-1:0] io_in,
  output logic done,
  output logic [WIDTH-1:0] rd_data,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic [WIDTH-1:0] io_out,
  output logic io_oe
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOW,
    ST_HIGH
  } phase_t;

  phase_t phase;
  logic [7:0] count;
  logic is_read;

  // strobe low for HOLD cycles, then high for HOLD cycles before done
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      phase <= ST_IDLE;
      count <= 8'h00;
      done <= 1'b0;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
      io_out <= '0;
      io_oe <= 1'b0;
      is_read <= 1'b0;
      rd_data <= '0;
    end
    else
    begin
      done <= 1'b0;
      case (phase)
        ST_IDLE:
        begin
          if (start)
          begin
            is_read <= (kind == flash_host_pkg::CYC_READ);
            cle <= (kind == flash_host_pkg::CYC_CMD);
            ale <= (kind == flash_host_pkg::CYC_ADDR);
            we_n <= (kind == flash_host_pkg::CYC_READ);
            re_n <= (kind != flash_host_pkg::CYC_READ);
            io_out <= WIDTH'(value);
            io_oe <= (kind != flash_host_pkg::CYC_READ);
            count <= 8'h00;
            phase <= ST_LOW;
          end
        end
        ST_LOW:
        begin
          count <= count + 8'h01;
          if (count == 8'(HOLD - 1))
          begin
            // sample read data just before the rising read strobe
            if (is_read)
              rd_data <= io_in;
            we_n <= 1'b1;
            re_n <= 1'b1;
            count <= 8'h00;
            phase <= ST_HIGH;
          end
        end
        default:
        begin
          count <= count + 8'h01;
          if (count == 8'(HOLD - 1))
          begin
            cle <= 1'b0;
            ale <= 1'b0;
            io_oe <= 1'b0;
            done <= 1'b1;
            phase <= ST_IDLE;
          end
        end
      endcase
    end
  end

endmodule // flash_bus_cycle
`default_nettype wire

/* design/flash_signature_host.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_signature_host #(
  parameter int WIDTH = 16,
  parameter int ROW_BITS = 24,
  parameter int SPARE_COL = 2048,
  parameter int SIXTH_OFFSET = 5
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  input wire logic [WIDTH-1:0] io_in,
  input wire logic ready_busy,
  output logic [WIDTH-1:0] io_out,
  output logic io_oe,
  output logic cle,
  output logic ale,
  output logic ce_n,
  output logic we_n,
  output logic re_n,
  output logic wp_n
);

  // ************************************************************
  // state and sequence
  // ************************************************************
  typedef enum logic [2:0] {
    H_IDLE,
    H_ISSUE,
    H_WAIT_CYCLE,
    H_WAIT_READY,
    H_FINISH
  } host_state_t;

  typedef enum logic [1:0] {
    OP_ID,
    OP_MARK,
    OP_ERASE
  } op_t;

  localparam int IRQ_W = flash_host_pkg::IRQ_WIDTH;
  localparam logic [3:0] STEP_ONE = 4'h1;

  host_state_t state;
  op_t op;
  logic [3:0] step;
  logic [ROW_BITS-1:0] block_addr;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [7:0] id_item [flash_host_pkg::SIGNATURE_ITEMS];
  logic [7:0] flash_status;
  logic [7:0] marker_first;
  logic [7:0] marker_sixth;
  logic marker_checked;
  logic [ROW_BITS-1:0] checked_block;
  logic unlock;
  logic cyc_start;
  flash_host_pkg::cycle_kind_t cyc_kind;
  logic [7:0] cyc_value;
  logic cyc_done;
  logic [WIDTH-1:0] cyc_data;
  logic cyc_cle;
  logic cyc_ale;
  logic cyc_we_n;
  logic cyc_re_n;
  logic [WIDTH-1:0] cyc_io_out;
  logic cyc_io_oe;
  logic rb_s1;
  logic rb_s2;
  logic rb_s3;
  logic rb_level;
  logic [IRQ_W-1:0] irq_set;

  logic [10:0] entry;
  logic [3:0] settle;

  // ************************************************************
  // sequence table: what each step of an operation drives
  // ************************************************************
  // returns {last, kind, value} for step s of operation o
  function automatic logic [10:0] seq_entry(input op_t o, input logic [3:0] s,
                                            input logic [ROW_BITS-1:0] row);
    logic [10:0] e;
    e = {1'b1, flash_host_pkg::CYC_READ, 8'h00};
    case (o)
      OP_ID:
      begin
        if (s == 4'h0)
          e = {1'b0, flash_host_pkg::CYC_CMD, flash_host_pkg::CMD_SIGNATURE};
        else if (s == 4'h1)
          e = {1'b0, flash_host_pkg::CYC_ADDR, flash_host_pkg::ADDR_SIGNATURE};
        else
          e = {(s == 4'h5), flash_host_pkg::CYC_READ, 8'h00};
      end
      OP_MARK:
      begin
        // column = spare area start, then row of the block's first page
        if (s == 4'h0)
          e = {1'b0, flash_host_pkg::CYC_CMD, flash_host_pkg::CMD_READ};
        else if (s == 4'h1)
          e = {1'b0, flash_host_pkg::CYC_ADDR, 8'(SPARE_COL)};
        else if (s == 4'h2)
          e = {1'b0, flash_host_pkg::CYC_ADDR, 8'(SPARE_COL >> 8)};
        else if (s == 4'h3)
          e = {1'b0, flash_host_pkg::CYC_ADDR, row[7:0]};
        else if (s == 4'h4)
          e = {1'b0, flash_host_pkg::CYC_ADDR, row[15:8]};
        else if (s == 4'h5)
          e = {1'b0, flash_host_pkg::CYC_ADDR, row[23:16]};
        else if (s == 4'h6)
          e = {1'b0, flash_host_pkg::CYC_CMD, flash_host_pkg::CMD_READ_CONFIRM};
        else
          e = {(s == 4'(7 + SIXTH_OFFSET)), flash_host_pkg::CYC_READ, 8'h00};
      end
      default:
      begin
        if (s == 4'h0)
          e = {1'b0, flash_host_pkg::CYC_CMD, flash_host_pkg::CMD_ERASE_SETUP};
        else if (s == 4'h1)
          e = {1'b0, flash_host_pkg::CYC_ADDR, row[7:0]};
        else if (s == 4'h2)
          e = {1'b0, flash_host_pkg::CYC_ADDR, row[15:8]};
        else if (s == 4'h3)
          e = {1'b0, flash_host_pkg::CYC_ADDR, row[23:16]};
        else if (s == 4'h4)
          e = {1'b0, flash_host_pkg::CYC_CMD, flash_host_pkg::CMD_ERASE_CONFIRM};
        else if (s == 4'h5)
          e = {1'b0, flash_host_pkg::CYC_CMD, flash_host_pkg::CMD_STATUS};
        else
          e = {1'b1, flash_host_pkg::CYC_READ, 8'h00};
      end
    endcase
    return e;
  endfunction

  // entry of the step in progress, shared by issue and completion
  assign entry = seq_entry(op, step, block_addr);

  // ************************************************************
  // bus cycle engine
  // ************************************************************
  flash_bus_cycle #(
    .WIDTH(WIDTH)
  ) u_cycle (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(cyc_start),
    .kind(cyc_kind),
    .value(cyc_value),
    .io_in(io_in),
    .done(cyc_done),
    .rd_data(cyc_data),
    .cle(cyc_cle),
    .ale(cyc_ale),
    .we_n(cyc_we_n),
    .re_n(cyc_re_n),
    .io_out(cyc_io_out),
    .io_oe(cyc_io_oe)
  );

  // ready/busy pin: three stages, a change counts when stages two and three agree
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rb_s1 <= 1'b0;
      rb_s2 <= 1'b0;
      rb_s3 <= 1'b0;
      rb_level <= 1'b0;
    end
    else
    begin
      rb_s1 <= ready_busy;
      rb_s2 <= rb_s1;
      rb_s3 <= rb_s2;
      if (rb_s2 == rb_s3)
        rb_level <= rb_s3;
    end
  end

  // ************************************************************
  // operation sequencer
  // ************************************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state <= H_IDLE;
      op <= OP_ID;
      step <= 4'h0;
      cyc_start <= 1'b0;
      cyc_kind <= flash_host_pkg::CYC_CMD;
      settle <= 4'h0;
      cyc_value <= 8'h00;
      ce_n <= 1'b1;
      irq_set <= '0;
      flash_status <= 8'h00;
      marker_first <= 8'h00;
      marker_sixth <= 8'h00;
      marker_checked <= 1'b0;
      checked_block <= '0;
      for (int i = 0; i < flash_host_pkg::SIGNATURE_ITEMS; i++)
        id_item[i] <= 8'h00;
    end
    else
    begin
      cyc_start <= 1'b0;
      irq_set <= '0;
      case (state)
        H_IDLE:
        begin
          if (wr && addr == flash_host_pkg::REG_CTRL)
          begin
            if (wdata[flash_host_pkg::CTRL_ID_BIT])
            begin
              op <= OP_ID;
              state <= H_ISSUE;
            end
            else if (wdata[flash_host_pkg::CTRL_MARK_BIT])
            begin
              op <= OP_MARK;
              state <= H_ISSUE;
            end
            else if (wdata[flash_host_pkg::CTRL_ERASE_BIT])
            begin
              // no erase until the marker of this very block was read
              // and if write-lock was held before this write the erase is not even sent
              if (!marker_checked || checked_block != block_addr || !unlock)
                irq_set[flash_host_pkg::IRQ_REFUSED] <= 1'b1;
              else
              begin
                op <= OP_ERASE;
                state <= H_ISSUE;
              end
            end
            step <= 4'h0;
          end
        end
        H_ISSUE:
        begin
          ce_n <= 1'b0;
          cyc_kind <= flash_host_pkg::cycle_kind_t'(entry[9:8]);
          cyc_value <= entry[7:0];
          settle <= 4'h0;
          cyc_start <= 1'b1;
          state <= H_WAIT_CYCLE;
        end
        H_WAIT_CYCLE:
        begin
          if (cyc_done)
          begin
            // keep only the low byte; on wide parts the upper byte is zero
            if (op == OP_ID && step >= 4'h2)
              id_item[2'(step - 4'h2)] <= cyc_data[7:0];
            if (op == OP_MARK && step == 4'h7)
              marker_first <= cyc_data[7:0];
            if (op == OP_MARK && step == 4'(7 + SIXTH_OFFSET))
              marker_sixth <= cyc_data[7:0];
            if (op == OP_ERASE && step == 4'h6)
              flash_status <= cyc_data[7:0];
            if (entry[10])
              state <= H_FINISH;
            else if ((op == OP_MARK && step == 4'h6) || (op == OP_ERASE && step == 4'h4))
              state <= H_WAIT_READY;
            else
              state <= H_ISSUE;
            step <= step + STEP_ONE;
          end
        end
        H_WAIT_READY:
        begin
          // ready still reads high for a few cycles after the confirm, so it is
          // not trusted until the settle count has run out
          if (settle != 4'(flash_host_pkg::BUSY_SETTLE_CYCLES))
            settle <= settle + 4'h1;
          else if (rb_level)
            state <= H_ISSUE;
        end
        default:
        begin
          ce_n <= 1'b1;
          state <= H_IDLE;
          irq_set[flash_host_pkg::IRQ_DONE] <= 1'b1;
          if (op == OP_MARK)
          begin
            marker_checked <= 1'b1;
            checked_block <= block_addr;
            // x8 needs first and sixth spare bytes, x16 only the first word
            if (marker_first != flash_host_pkg::ERASED_BYTE ||
                (!id_item[3][flash_host_pkg::B4_WIDE_BIT] &&
                 marker_sixth != flash_host_pkg::ERASED_BYTE))
              irq_set[flash_host_pkg::IRQ_BAD] <= 1'b1;
          end
          if (op == OP_ERASE)
          begin
            // a failed erase asks software to retire the block
            if (flash_status[flash_host_pkg::SR_FAIL_BIT] ||
                !flash_status[flash_host_pkg::SR_UNLOCK_BIT])
              irq_set[flash_host_pkg::IRQ_FAIL] <= 1'b1;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // pin outputs: all registered
  // ************************************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
      io_out <= '0;
      io_oe <= 1'b0;
      wp_n <= 1'b0;
    end
    else
    begin
      cle <= cyc_cle;
      ale <= cyc_ale;
      we_n <= cyc_we_n;
      re_n <= cyc_re_n;
      io_out <= cyc_io_out;
      io_oe <= cyc_io_oe;
      wp_n <= unlock;
    end
  end

  // ************************************************************
  // software registers
  // ************************************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      unlock <= 1'b0;
      block_addr <= '0;
      irq_mask <= '0;
    end
    else if (wr)
    begin
      if (addr == flash_host_pkg::REG_CTRL)
        unlock <= wdata[flash_host_pkg::CTRL_UNLOCK_BIT];
      else if (addr == flash_host_pkg::REG_BLOCK_ADDR && state == H_IDLE)
        block_addr <= wdata[ROW_BITS-1:0];
      else if (addr == flash_host_pkg::REG_IRQ_MASK)
        irq_mask <= wdata[IRQ_W-1:0];
    end
  end

  // sticky events: a new event wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irq_status <= '0;
    else if (wr && addr == flash_host_pkg::REG_IRQ_STATUS)
      irq_status <= (irq_status & ~wdata[IRQ_W-1:0]) | irq_set;
    else
      irq_status <= irq_status | irq_set;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |((irq_status | irq_set) & irq_mask);
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdata <= 32'h0000_0000;
    else if (!rd)
      rdata <= 32'h0000_0000;
    else if (addr == flash_host_pkg::REG_CTRL)
      rdata <= {28'h0000000, unlock, 2'b00, state != H_IDLE};
    else if (addr == flash_host_pkg::REG_BLOCK_ADDR)
      rdata <= 32'(block_addr);
    else if (addr == flash_host_pkg::REG_IRQ_STATUS)
      rdata <= 32'(irq_status);
    else if (addr == flash_host_pkg::REG_IRQ_MASK)
      rdata <= 32'(irq_mask);
    else if (addr == flash_host_pkg::REG_ID_LO)
      rdata <= {16'h0000, id_item[1], id_item[0]};
    else if (addr == flash_host_pkg::REG_ID_HI)
      rdata <= {16'h0000, id_item[3], id_item[2]};
    else if (addr == flash_host_pkg::REG_GEOMETRY)
      // decoded geometry: log2 of dies, cells, pages, then flags
      rdata <= {16'h0000,
                id_item[3][flash_host_pkg::B4_ACC_HI_BIT],
                id_item[3][flash_host_pkg::B4_ACC_LO_BIT],
                id_item[3][flash_host_pkg::B4_BLOCK_LSB +: 2],
                id_item[3][flash_host_pkg::B4_WIDE_BIT],
                id_item[3][flash_host_pkg::B4_SPARE_BIT],
                id_item[3][flash_host_pkg::B4_PAGE_LSB +: 2],
                id_item[2][flash_host_pkg::B3_CACHE_BIT],
                id_item[2][flash_host_pkg::B3_INTERLEAVE_BIT],
                id_item[2][flash_host_pkg::B3_PAGES_LSB +: 2],
                id_item[2][flash_host_pkg::B3_CELL_LSB +: 2],
                id_item[2][flash_host_pkg::B3_DIE_LSB +: 2]};
    else if (addr == flash_host_pkg::REG_FLASH_STATUS)
      rdata <= {24'h000000, flash_status};
    else if (addr == flash_host_pkg::REG_MARKER)
      rdata <= {15'h0000, marker_checked, marker_sixth, marker_first};
    else
      rdata <= 32'h0000_0000;
  end

  // lockout below lockout_threshold and single-bit correction are device and
  // software concerns; this host does not compute check bits

endmodule // flash_signature_host
`default_nettype wire

/* test/flash_host_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// pin checks
// ****
module flash_host_checker #(
  parameter int WIDTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] io_out,
  input wire logic io_oe,
  input wire logic cle,
  input wire logic ale,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // the signature command must be followed by its address byte
  sequence sig_cmd_s;
    $rose(cle) && io_out[7:0] == 8'h90;
  endsequence
  sequence sig_addr_s;
    ##[1:12] $rose(ale) && io_out[7:0] == 8'h00;
  endsequence
  reset_pins_a: assert property (disable iff (1'b0) rst |-> ce_n && we_n && re_n && !cle
    && !ale && !io_oe && !wp_n) else $error("pins not idle in reset");
  sig_order_a: assert property (sig_cmd_s |-> sig_addr_s)
    else $error("no address after signature");
  latch_excl_a: assert property (!(cle && ale)) else $error("cle and ale together");
  we_pulse_a: assert property ($fell(we_n) |-> !we_n [*3] ##1 we_n)
    else $error("bad write strobe");
  re_pulse_a: assert property ($fell(re_n) |-> !re_n [*3] ##1 re_n)
    else $error("bad read strobe");
  read_release_a: assert property (!re_n |-> !io_oe && !ce_n)
    else $error("bus driven in read");
  erase_locked_a: assert property (!(cle && io_out[7:0] == 8'hd0 && !wp_n))
    else $error("erase confirm while locked");
  erase_setup_a: assert property (cle && io_out[7:0] == 8'h60 |-> wp_n)
    else $error("erase setup while locked");
endmodule // flash_host_checker
bind flash_signature_host flash_host_checker #(.WIDTH(WIDTH)) u_flash_host_checker (
  .clk_sys, .rst, .io_out, .io_oe, .cle, .ale, .ce_n, .we_n, .re_n, .wp_n);
`default_nettype wire

/* test/flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// flash device model
// ****
module flash_model #(
  parameter logic [7:0] MAKER = 8'h5a, // arbitrary value
  parameter logic [7:0] DEVICE = 8'h3c // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic cle,
  input wire logic ale,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [15:0] io_out,
  input wire logic [7:0] item3,
  input wire logic [7:0] item4,
  input wire logic [7:0] mark6,
  input wire logic fail_en,
  output logic [15:0] io_in,
  output logic ready_busy
);
  logic [9:0] cap;
  logic [7:0] cmd = 8'h00;
  logic [15:0] dat;
  logic [15:0] last = 16'h0;
  logic [7:0] items [4];
  logic pw = 1'b1;
  logic pr = 1'b1;
  int idx = 0;
  int busy = 0;
  // latch a cycle while the strobe is low, act on its rising edge
  always @(posedge clk_sys)
  begin
    pw <= we_n;
    pr <= re_n;
    if (busy > 0)
      busy <= busy - 1;
    if (!we_n)
      cap <= {cle, ale, io_out[7:0]};
    if (we_n && !pw && !ce_n)
    begin
      idx <= 0;
      if (cap[9])
        cmd <= cap[7:0];
      if (cap[9] && (cap[7:0] == 8'h30 || (cap[7:0] == 8'hd0 && wp_n)))
        busy <= 20;
    end
    if (re_n && !pr)
    begin
      idx <= idx + 1;
      last <= dat;
    end
  end
  assign items = '{MAKER, DEVICE, item3, item4};
  // item for the current mode and read index
  always_comb
    case (cmd)
      8'h90: dat = {8'h0, items[idx[1:0]]};
      8'h70: dat = {8'h0, wp_n, busy == 0, 5'h0, fail_en};
      default: dat = {8'h0, idx == 5 ? mark6 : 8'hff};
    endcase
  // a released bus shows the inverse of the last item, never a stale copy
  assign io_in = (!re_n && !ce_n) ? dat : ~last;
  assign ready_busy = busy == 0;
endmodule // flash_model
`default_nettype wire

/* test/test_flash_signature_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module test_flash_signature_host;
  typedef struct {logic [31:0] exp; logic [31:0] msk; string name;} note_t;
  logic clk_sys = 0, rst = 0, wr = 0, rd = 0, rd_d = 0, fail_en = 0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic irq, ready_busy, io_oe, cle, ale, ce_n, we_n, re_n, wp_n;
  logic [15:0] io_in, io_out;
  logic [7:0] item3 = 8'h00, item4 = 8'h00, mark6 = 8'hff;
  note_t q[$];
  note_t n;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  initial forever #5 clk_sys = ~clk_sys;
  flash_signature_host u_flash_signature_host (.clk_sys, .rst, .addr, .wdata, .wr, .rd,
    .rdata, .irq, .io_in, .ready_busy, .io_out, .io_oe, .cle, .ale, .ce_n, .we_n, .re_n, .wp_n);
  flash_model #(.MAKER(8'h5a), .DEVICE(8'h3c)) u_flash_model (.clk_sys, .cle, .ale, .ce_n,
    .we_n, .re_n, .wp_n, .io_out, .item3, .item4, .mark6, .fail_en, .io_in, .ready_busy);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  // the expected value is queued when the read is issued
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    q.push_back('{e, m, "register"});
    @(posedge clk_sys);
    rd <= 1'b0;
  endtask
  // bounded wait; idle margin lets the controller return before the next start
  task automatic wait_irq();
    for (int i = 0; i < 3000 && irq !== 1'b1; i++)
      @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1, "irq");
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // read data stand one cycle after the strobe; cycle ceiling cuts a hang short
  always @(posedge clk_sys)
  begin
    rd_d <= rd;
    cyc++;
    if (rd_d)
    begin
      n = q.pop_front();
      chk(rdata & n.msk, n.exp, n.name);
    end
    if (cyc == 40000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  initial
  begin
    void'($urandom(32'ha35c6221));
    item3 = $urandom;
    item4 = $urandom & 8'hbf;
    // a real edge on reset, away from the clock, so every host flop resets before edge one
    #1 rst = 1'b1;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rd_reg(4'h0, 32'h0, '1);
    rd_reg(4'h2, 32'h0, '1);
    rd_reg(4'h3, 32'h0, '1);
    rd_reg(4'hf, 32'h0, '1);
    wr_reg(4'h3, 32'h1);
    wr_reg(4'h0, 32'h1);
    wait_irq();
    rd_reg(4'h4, {24'h3c, 8'h5a}, '1);
    rd_reg(4'h5, {16'h0, item4, item3}, '1);
    rd_reg(4'h6, {item4[7], item4[3], item4[5:4], item4[6], item4[2], item4[1:0], item3}, '1);
    wr_reg(4'h2, 32'hf);
    rd_reg(4'h2, 32'h0, 32'hf);
    wr_reg(4'h1, 32'h5);
    wr_reg(4'h0, 32'h2);
    wait_irq();
    rd_reg(4'h8, 32'h1ffff, '1);
    rd_reg(4'h2, 32'h1, 32'h5);
    wr_reg(4'h2, 32'hf);
    wr_reg(4'h3, 32'h8);
    wr_reg(4'h0, 32'h4);
    wait_irq();
    rd_reg(4'h2, 32'h8, 32'h8);
    chk({31'h0, wp_n}, 32'h0, "wp_n");
    fail_en <= 1'b1;
    wr_reg(4'h2, 32'hf);
    wr_reg(4'h3, 32'h2);
    wr_reg(4'h0, 32'h8);
    wr_reg(4'h0, 32'hc);
    wait_irq();
    rd_reg(4'h7, 32'h81, 32'h81);
    rd_reg(4'h2, 32'h3, 32'h3);
    wr_reg(4'h3, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0, "masked irq");
    mark6 <= 8'($urandom % 255);
    wr_reg(4'h2, 32'hf);
    wr_reg(4'h3, 32'h4);
    wr_reg(4'h0, 32'ha);
    wait_irq();
    rd_reg(4'h8, {16'h1, mark6, 8'hff}, '1);
    wr_reg(4'h1, 32'h6);
    wr_reg(4'h2, 32'hf);
    wr_reg(4'h3, 32'h8);
    wr_reg(4'h0, 32'hc);
    wait_irq();
    rd_reg(4'h2, 32'h8, 32'h8);
    repeat (2) @(posedge clk_sys);
    print_verdict();
  end
endmodule // test_flash_signature_host
`default_nettype wire
